//--- logic/mult_unit.sv
// Behaviour
// - Decode opcode zero, four function codes, bits 10..6 pick low or high.
// - Signed word low: low 32 bits of signed 32x32 product.
// - Signed word high: upper 32 bits of signed 64-bit product.
// - Unsigned word low: low 32 bits of unsigned product.
// - Unsigned word high: upper 32 bits of unsigned product.
// - Signed doubleword: 128-bit product, low or high 64 bits written.
// - Unsigned doubleword: 128-bit product, low or high 64 bits written.
// - Word results are sign-extended from bit 31 to 64 bits.
// - Word low results ignore operand bits 32 through 63.
// - Signed word high with badly extended inputs is undefined; no check.
// - Unsigned word high with badly extended inputs is undefined.
// - All word operations use only the low word of each source.
// - Doubleword forms trap as reserved when 64-bit mode is off, no write.
// - Word forms never trap; no overflow exception ever.
// - Reads of the pending destination stall until the result is written.
// - Overlap is invisible; results match strictly sequential execution.
// - Latency may depend on operand values.
// - Product is formed at twice the operand width, exact for signedness.
// - Low-then-high of same operands may reuse one product.
// - Only the named destination is written; no accumulator exists.
module mult_unit
  import mult_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request from decode
  input wire mult_req_t req,
  input wire logic mode64_en,
  output logic req_ready,
  output logic trap_reserved,
  // Hazard check from later instructions
  input wire logic [NREAD*IDX_W-1:0] read_index,
  output logic stall,
  // Writeback
  output mult_wb_t wb
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  mult_op_t dec;
  logic [5:0] func;
  logic [4:0] sel;
  logic [IDX_W-1:0] dest;

  assign func = req.instr[FUNC_MSB:FUNC_LSB];
  assign sel = req.instr[SEL_MSB:SEL_LSB];
  assign dest = req.instr[RD_MSB:RD_LSB];

  always_comb begin
    dec = '0;
    if (req.instr[OPC_MSB:OPC_LSB] == OPC_SPECIAL && (sel == SEL_LOW || sel == SEL_HIGH)) begin
      dec.high = sel == SEL_HIGH;
      case (func)
        FUNC_SIGNED_WORD: begin
          dec.is_mult = 1'b1;
          dec.is_signed = 1'b1;
        end
        FUNC_UNSIGNED_WORD: begin
          dec.is_mult = 1'b1;
        end
        FUNC_SIGNED_DWORD: begin
          dec.is_mult = 1'b1;
          dec.is_signed = 1'b1;
          dec.is_dword = 1'b1;
        end
        FUNC_UNSIGNED_DWORD: begin
          dec.is_mult = 1'b1;
          dec.is_dword = 1'b1;
        end
        default: begin
          dec.is_mult = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Operand shaping
  // ----------------------------------------
  // Word forms look only at the low word, so badly extended inputs
  // give a defined answer instead of needing a check.
  logic [XLEN-1:0] opa;
  logic [XLEN-1:0] opb;
  logic [XLEN-1:0] mag_a;
  logic [XLEN-1:0] mag_b;
  logic negate;

  always_comb begin
    if (dec.is_dword) begin
      opa = req.src_a;
      opb = req.src_b;
    end else begin
      opa = {{WLEN{dec.is_signed & req.src_a[WLEN-1]}}, req.src_a[WLEN-1:0]};
      opb = {{WLEN{dec.is_signed & req.src_b[WLEN-1]}}, req.src_b[WLEN-1:0]};
    end
  end

  always_comb begin
    negate = dec.is_signed & (opa[XLEN-1] ^ opb[XLEN-1]);
    mag_a = (dec.is_signed && opa[XLEN-1]) ? (~opa + 1'b1) : opa;
    mag_b = (dec.is_signed && opb[XLEN-1]) ? (~opb + 1'b1) : opb;
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  mult_state_t state_q;
  logic accept;
  logic trap_now;
  logic hit_cache;
  logic start;
  logic core_done;
  logic [PLEN-1:0] core_prod;

  logic cache_valid_q;
  logic [XLEN-1:0] cache_a_q;
  logic [XLEN-1:0] cache_b_q;
  logic cache_signed_q;
  logic [PLEN-1:0] cache_prod_q;

  mult_op_t op_q;
  logic [IDX_W-1:0] dest_q;
  logic [XLEN-1:0] cur_a_q;
  logic [XLEN-1:0] cur_b_q;

  // A new request waits until the one in flight has written back,
  // which keeps write order strictly sequential.
  assign req_ready = state_q == ST_IDLE;
  assign accept = req.valid && req_ready && dec.is_mult;
  assign trap_now = accept && dec.is_dword && !mode64_en;

  // Words are stored extended to 64 bits, so one compare covers both widths.
  assign hit_cache = cache_valid_q && cache_a_q == opa && cache_b_q == opb
    && cache_signed_q == dec.is_signed;
  assign start = accept && !trap_now && !hit_cache;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && !trap_now) begin
            state_q <= hit_cache ? ST_WB : ST_RUN;
          end
        end
        ST_RUN: begin
          if (core_done) begin
            state_q <= ST_WB;
          end
        end
        ST_WB: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_q <= '0;
      dest_q <= ZERO_REG;
      cur_a_q <= '0;
      cur_b_q <= '0;
    end else if (accept && !trap_now) begin
      op_q <= dec;
      dest_q <= dest;
      cur_a_q <= opa;
      cur_b_q <= opb;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trap_reserved <= 1'b0;
    end else begin
      trap_reserved <= trap_now;
    end
  end

  // ----------------------------------------
  // Product and cache
  // ----------------------------------------
  mult_core u_core (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start),
    .negate(negate),
    .mag_a(mag_a),
    .mag_b(mag_b),
    .done(core_done),
    .product(core_prod)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cache_valid_q <= 1'b0;
      cache_a_q <= '0;
      cache_b_q <= '0;
      cache_signed_q <= 1'b0;
      cache_prod_q <= '0;
    end else if (state_q == ST_RUN && core_done) begin
      cache_valid_q <= 1'b1;
      cache_a_q <= cur_a_q;
      cache_b_q <= cur_b_q;
      cache_signed_q <= op_q.is_signed;
      cache_prod_q <= core_prod;
    end
  end

  function automatic logic [XLEN-1:0] pick(input logic [PLEN-1:0] p, input mult_op_t op);
    logic [WLEN-1:0] w;
    w = op.high ? p[2*WLEN-1:WLEN] : p[WLEN-1:0];
    if (op.is_dword) begin
      pick = op.high ? p[PLEN-1:XLEN] : p[XLEN-1:0];
    end else begin
      pick = {{WLEN{w[WLEN-1]}}, w};
    end
  endfunction : pick

  // ----------------------------------------
  // Writeback
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb <= '0;
    end else if (state_q == ST_IDLE && accept && !trap_now && hit_cache) begin
      wb.valid <= dest != ZERO_REG;
      wb.index <= dest;
      wb.data <= pick(cache_prod_q, dec);
    end else if (state_q == ST_RUN && core_done) begin
      wb.valid <= dest_q != ZERO_REG;
      wb.index <= dest_q;
      wb.data <= pick(core_prod, op_q);
    end else begin
      wb.valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interlock
  // ----------------------------------------
  logic pending;

  mult_scoreboard u_board (
    .clk(clk),
    .sys_rst(sys_rst),
    .set(accept && !trap_now),
    .set_index(dest),
    .clear(state_q == ST_WB),
    .read_index(read_index),
    .stall(stall),
    .pending(pending)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic signed [PLEN-1:0] ref_s;
  logic [PLEN-1:0] ref_u;
  logic [PLEN-1:0] ref_q;

  assign ref_s = $signed(opa) * $signed(opb);
  assign ref_u = opa * opb;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_q <= '0;
    end else if (accept) begin
      ref_q <= dec.is_signed ? ref_s : ref_u;
    end
  end

  // A multiplier with its top bit set needs the load, one shift per bit, the finish and the state step.
  localparam int WB_LIMIT = MAX_LAT + 1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_trap_dword: assert property (
    accept && dec.is_dword && !mode64_en |=> trap_reserved && state_q == ST_IDLE && !wb.valid)
    else $error("doubleword op in 32-bit mode did not trap cleanly");

  chk_word_no_trap: assert property (
    accept && !dec.is_dword |=> !trap_reserved)
    else $error("word multiply raised a trap");

  chk_product_exact: assert property (
    state_q == ST_WB && wb.valid |-> wb.data == pick(ref_q, op_q))
    else $error("written product differs from exact product");

  chk_sign_extend: assert property (
    state_q == ST_WB && wb.valid && !op_q.is_dword |-> wb.data[XLEN-1:WLEN] == {WLEN{wb.data[WLEN-1]}})
    else $error("word result not sign-extended");

  chk_word_mask: assert property (
    accept && !trap_now && !dec.is_dword |=> cur_a_q[WLEN-1:0] == $past(req.src_a[WLEN-1:0])
      && cur_a_q[XLEN-1:WLEN] == {WLEN{op_q.is_signed & cur_a_q[WLEN-1]}})
    else $error("word operand upper bits leaked");

  chk_latency_bound: assert property (
    start |-> ##[1:WB_LIMIT] state_q == ST_WB)
    else $error("multiply took longer than worst case");

  chk_fused_fast: assert property (
    accept && !trap_now && hit_cache |=> state_q == ST_WB && wb.valid == (dest_q != ZERO_REG))
    else $error("fused half did not write next cycle");

  chk_zero_dest: assert property (
    accept && !trap_now && dest == ZERO_REG |=> !pending && !stall)
    else $error("register zero held an interlock");

  chk_stall_pending: assert property (
    state_q == ST_RUN && read_index[IDX_W-1:0] == dest_q && dest_q != ZERO_REG |-> stall)
    else $error("read of pending destination not stalled");

  chk_single_write: assert property (
    wb.valid |-> state_q == ST_WB ##1 !wb.valid && req_ready)
    else $error("writeback not single and in order");

  chk_trap_no_lock: assert property (
    trap_now |=> !pending && !stall)
    else $error("trapped doubleword op set an interlock");

  chk_wb_no_stall: assert property (
    state_q == ST_WB |-> !stall)
    else $error("writeback cycle still stalled a reader");

  chk_other_ignored: assert property (
    req.valid && req_ready && !dec.is_mult |=> state_q == ST_IDLE && !trap_reserved && !wb.valid)
    else $error("non-multiply encoding was acted on");

  cov_trap: cover property (trap_reserved);
  cov_fused: cover property (accept && hit_cache && dec.high);
  cov_dword_high: cover property (state_q == ST_WB && op_q.is_dword && op_q.high && wb.valid);
  cov_stall: cover property (stall ##1 wb.valid);

endmodule : mult_unit

//--- inc/mult_pkg.sv
package mult_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int XLEN = 64;
  localparam int WLEN = 32;
  localparam int PLEN = 128;
  localparam int IDX_W = 5;
  localparam int NREAD = 2;
  // Worst case: one cycle per multiplier bit, plus load and finish.
  localparam int MAX_LAT = XLEN + 2;

  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int RD_MSB = 15;
  localparam int RD_LSB = 11;
  localparam int SEL_MSB = 10;
  localparam int SEL_LSB = 6;
  localparam int FUNC_MSB = 5;
  localparam int FUNC_LSB = 0;

  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] FUNC_SIGNED_WORD = 6'h18;
  localparam logic [5:0] FUNC_UNSIGNED_WORD = 6'h19;
  localparam logic [5:0] FUNC_SIGNED_DWORD = 6'h1c;
  localparam logic [5:0] FUNC_UNSIGNED_DWORD = 6'h1d;
  localparam logic [4:0] SEL_LOW = 5'h02;
  localparam logic [4:0] SEL_HIGH = 5'h03;
  localparam logic [IDX_W-1:0] ZERO_REG = 5'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [XLEN-1:0] src_a;
    logic [XLEN-1:0] src_b;
  } mult_req_t;

  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] index;
    logic [XLEN-1:0] data;
  } mult_wb_t;

  typedef struct packed {
    logic is_mult;
    logic is_signed;
    logic is_dword;
    logic high;
  } mult_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_WB = 2'b11
  } mult_state_t;

endpackage : mult_pkg

//--- logic/mult_core.sv
module mult_core
  import mult_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Start
  input wire logic start,
  input wire logic negate,
  input wire logic [XLEN-1:0] mag_a,
  input wire logic [XLEN-1:0] mag_b,
  // Result
  output logic done,
  output logic [PLEN-1:0] product
);

  logic [PLEN-1:0] acc_q;
  logic [PLEN-1:0] mcand_q;
  logic [XLEN-1:0] mplier_q;
  logic run_q;
  logic neg_q;
  logic finish;

  // Shift-add stops as soon as the multiplier runs out of ones above.
  assign finish = run_q && (mplier_q == '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q <= 1'b0;
    end else if (start) begin
      run_q <= 1'b1;
    end else if (finish) begin
      run_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= '0;
      mcand_q <= '0;
      mplier_q <= '0;
      neg_q <= 1'b0;
    end else if (start) begin
      acc_q <= '0;
      mcand_q <= {{(PLEN-XLEN){1'b0}}, mag_a};
      mplier_q <= mag_b;
      neg_q <= negate;
    end else if (run_q && !finish) begin
      if (mplier_q[0]) begin
        acc_q <= acc_q + mcand_q;
      end
      mcand_q <= {mcand_q[PLEN-2:0], 1'b0};
      mplier_q <= {1'b0, mplier_q[XLEN-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done <= 1'b0;
      product <= '0;
    end else begin
      done <= finish;
      if (finish) begin
        product <= neg_q ? (~acc_q + 1'b1) : acc_q;
      end
    end
  end

endmodule : mult_core

//--- logic/mult_scoreboard.sv
module mult_scoreboard
  import mult_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pending destination
  input wire logic set,
  input wire logic [IDX_W-1:0] set_index,
  input wire logic clear,
  // Read checks
  input wire logic [NREAD*IDX_W-1:0] read_index,
  output logic stall,
  output logic pending
);

  logic [IDX_W-1:0] index_q;
  logic [NREAD-1:0] hit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending <= 1'b0;
      index_q <= ZERO_REG;
    end else if (set && set_index != ZERO_REG) begin
      pending <= 1'b1;
      index_q <= set_index;
    end else if (clear) begin
      pending <= 1'b0;
    end
  end

  for (genvar i = 0; i < NREAD; i++) begin : g_read
    assign hit[i] = read_index[i*IDX_W +: IDX_W] == index_q;
  end

  // The writeback cycle forwards the value, so it need not stall.
  assign stall = pending && !clear && (|hit);

endmodule : mult_scoreboard

//--- tb/mult_pipe_model.sv
module mult_pipe_model
  import mult_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command from the bench
  input wire logic go,
  input wire logic [31:0] instr,
  input wire logic [XLEN-1:0] a,
  input wire logic [XLEN-1:0] b,
  output logic taken,
  // Request towards the multiplier
  output mult_req_t req,
  input wire logic req_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      taken <= 1'b0;
    end else begin
      taken <= req.valid && req_ready;
    end
  end

  // A released request shows inverted fields, so stale operands never look current.
  always_ff @(negedge clk) begin
    if (sys_rst) begin
      req <= '0;
    end else if (go) begin
      req <= {1'b1, instr, a, b};
    end else if (taken) begin
      req <= {1'b0, ~req.instr, ~req.src_a, ~req.src_b};
    end
  end
endmodule : mult_pipe_model

//--- tb/mult_unit_test.sv
module mult_unit_test
  import mult_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  logic mode64_en = 1'b1;
  logic taken, req_ready, trap_reserved, stall;
  logic [31:0] cmd_instr = 32'h0;
  logic [XLEN-1:0] cmd_a = '0;
  logic [XLEN-1:0] cmd_b = '0;
  logic [NREAD*IDX_W-1:0] read_index = '0;
  mult_req_t req;
  mult_wb_t wb;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int last_lat;
  logic [31:0] seed = 32'hbf5c37c5;
  logic [5:0] fns [4] = '{FUNC_SIGNED_WORD, FUNC_UNSIGNED_WORD, FUNC_SIGNED_DWORD, FUNC_UNSIGNED_DWORD};
  logic [63:0] ca [4] = '{64'hdead_beef_8000_0000, 64'hffff_ffff_ffff_ffff, 64'h8000_0000_0000_0000,
                          64'h0000_0000_0000_0000};
  logic [63:0] cb [4] = '{64'h1234_5678_8000_0000, 64'hffff_ffff_ffff_ffff, 64'h8000_0000_0000_0000,
                          64'h5555_0000_7fff_ffff};

  always #5 clk = ~clk;

  mult_unit mult_unit_i (.clk(clk), .sys_rst(sys_rst), .req(req), .mode64_en(mode64_en), .req_ready(req_ready),
    .trap_reserved(trap_reserved), .read_index(read_index), .stall(stall), .wb(wb));

  mult_pipe_model mult_pipe_model_i (.clk(clk), .sys_rst(sys_rst), .go(go), .instr(cmd_instr), .a(cmd_a),
    .b(cmd_b), .taken(taken), .req(req), .req_ready(req_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [63:0] r64();
    logic [31:0] h;
    h = rnd();
    return {h, rnd()};
  endfunction : r64

  // Reference works at full width, so both halves are exact for either signedness.
  function automatic logic [63:0] exp_res(input logic [5:0] fn, input logic [4:0] sel, input logic [63:0] a, b);
    logic sg;
    logic dw;
    logic [127:0] p;
    sg = (fn == FUNC_SIGNED_WORD) || (fn == FUNC_SIGNED_DWORD);
    dw = (fn == FUNC_SIGNED_DWORD) || (fn == FUNC_UNSIGNED_DWORD);
    if (!dw) begin
      a = sg ? {{32{a[31]}}, a[31:0]} : {32'h0, a[31:0]};
      b = sg ? {{32{b[31]}}, b[31:0]} : {32'h0, b[31:0]};
    end
    p = (sg ? {{64{a[63]}}, a} : {64'h0, a}) * (sg ? {{64{b[63]}}, b} : {64'h0, b});
    if (dw) return (sel == SEL_HIGH) ? p[127:64] : p[63:0];
    return (sel == SEL_HIGH) ? {{32{p[63]}}, p[63:32]} : {{32{p[31]}}, p[31:0]};
  endfunction : exp_res

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // One operation from command to writeback; called and left at a falling edge.
  task automatic run(input logic [5:0] fn, input logic [4:0] sel, input logic [4:0] rd,
                     input logic [63:0] a, input logic [63:0] b, input logic m64);
    logic tr;
    logic ign;
    logic hit;
    logic trp;
    logic [63:0] d;
    logic [31:0] r;
    int n;
    r = rnd();
    ign = sel != SEL_LOW && sel != SEL_HIGH;
    tr = !ign && !m64 && (fn == FUNC_SIGNED_DWORD || fn == FUNC_UNSIGNED_DWORD);
    hit = 1'b0;
    trp = 1'b0;
    d = '0;
    read_index <= r[0] ? {rd, rd + 5'd1} : {rd + 5'd1, rd};
    go <= 1'b1;
    cmd_instr <= {OPC_SPECIAL, r[10:1], rd, sel, fn};
    cmd_a <= a;
    cmd_b <= b;
    mode64_en <= m64;
    @(negedge clk);
    go <= 1'b0;
    for (n = 0; n < 8 && taken !== 1'b1; n++) @(negedge clk);
    check("taken", 64'(taken), 64'h1);
    for (n = 0; n < MAX_LAT + 4; n++) begin
      if (hit || ((trp || ign) && n > 3)) break;
      if (wb.valid === 1'b1) begin
        hit = 1'b1;
        d = wb.data;
        last_lat = n;
        check("wb_index", 64'(wb.index), 64'(rd));
      end
      trp |= (trap_reserved === 1'b1);
      check("stall", 64'(stall), 64'(!tr && !ign && rd != ZERO_REG && !hit));
      if (rd != ZERO_REG || tr || ign) check("ready_busy", 64'(req_ready), 64'(tr || ign));
      @(negedge clk);
    end
    check("trap", 64'(trp), 64'(tr));
    check("wb_seen", 64'(hit), 64'(!tr && !ign && rd != ZERO_REG));
    if (hit) check("result", d, exp_res(fn, sel, a, b));
    check("ready_after", 64'(req_ready), 64'h1);
  endtask : run

  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [63:0] a;
    logic [63:0] b;
    repeat (16) @(negedge clk);
    check("rst_ready", 64'(req_ready), 64'h1);
    check("rst_wb", 64'(wb.valid), 64'h0);
    check("rst_trap", 64'(trap_reserved), 64'h0);
    sys_rst <= 1'b0;
    @(negedge clk);
    $display("test reset done");
    // Every code and half against sign-boundary operands with junk upper words.
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) begin
        run(fns[i / 2], (i % 2) ? SEL_HIGH : SEL_LOW, 5'(i * 4 + j + 1), ca[j], cb[j], 1'b1);
      end
    end
    $display("test corners done");
    run(FUNC_SIGNED_DWORD, SEL_LOW, 5'd7, r64(), r64(), 1'b0);
    run(FUNC_UNSIGNED_DWORD, SEL_HIGH, 5'd8, r64(), r64(), 1'b0);
    run(FUNC_UNSIGNED_WORD, SEL_HIGH, 5'd9, r64(), r64(), 1'b0);
    run(FUNC_SIGNED_WORD, 5'h04, 5'd10, r64(), r64(), 1'b1);
    run(FUNC_UNSIGNED_DWORD, 5'h00, 5'd11, r64(), r64(), 1'b0);
    $display("test trap done");
    a = r64();
    b = r64();
    run(FUNC_SIGNED_DWORD, SEL_LOW, 5'd3, a, b, 1'b1);
    run(FUNC_SIGNED_DWORD, SEL_HIGH, 5'd4, a, b, 1'b1);
    check("fused_latency", 64'(last_lat <= 1), 64'h1);
    $display("test fusion done");
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      a = r64();
      b = r64() >> r[11:6];
      run(fns[r[1:0]], r[2] ? SEL_HIGH : SEL_LOW, r[16:12], a, b, r[20:18] != 3'h0);
    end
    $display("test random done");
    end_sim();
  end
endmodule : mult_unit_test
